//--- rtl/rsc_top.sv
// Reset source combiner: merges all reset requests into the system reset
// line and keeps the software-visible reset cause / control register.
// Assumes requesters on the same clock give levels held until reset is
// seen; the pin and analog detector inputs are asynchronous.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Gather all listed sources as reset requests
// - Any active source asserts system reset
// - Reset forces subset, cause register kept
// - Each reset sets its own cause flag
// - Power-on leaves only power and brown-out set
// - Software sets or clears flags, no reset
// - Bit 15 flags trap conflict reset
// - Bit 14 flags illegal condition reset
// - Bit 9 flags configuration mismatch reset
// - Bit 8 keeps regulator active in sleep
// - Bit 7 flags master clear pin reset
// - Bit 6 flags reset instruction
// - Bit 5 enables watchdog unless fuse forces
// - Bit 4 flags watchdog time-out
// - Bit 3 flags device was in sleep
// - Bit 2 flags device was in idle
// - Bit 1 flags brown-out reset
// - Bit 0 flags power-on reset
// - Bits 13 to 10 read zero
// - Power and brown-out reset reselect clock
// - Filtered long master clear low resets
// - After release fetch starts at zero
module rsc_top (
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire logic MASTER_CLEAR_PIN_N_IN,
  input wire logic BROWN_OUT_DETECT_IN,
  input wire logic CLOCK_READY_IN,
  input wire logic WATCHDOG_FUSE_ENABLE_IN,
  input wire logic SOFT_RESET_REQ_IN,
  input wire logic WATCHDOG_TIMEOUT_IN,
  input wire logic CONFIG_MISMATCH_IN,
  input wire logic TRAP_CONFLICT_IN,
  input wire logic ILLEGAL_OPCODE_IN,
  input wire logic UNINIT_POINTER_IN,
  input wire logic SECURITY_RESET_IN,
  input wire logic SLEEP_WAKE_IN,
  input wire logic IDLE_WAKE_IN,
  input wire logic [rsc_pkg::ADDR_W-1:0] ADDR_IN,
  input wire logic [rsc_pkg::DATA_W-1:0] WR_DATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [rsc_pkg::DATA_W-1:0] RD_DATA_OUT,
  output logic SYSTEM_RESET_LINE_OUT,
  output logic CLOCK_RESELECT_OUT,
  output logic FETCH_START_OUT,
  output logic [rsc_pkg::FETCH_ADDR_W-1:0] FETCH_ADDR_OUT,
  output logic WATCHDOG_ENABLE_OUT,
  output logic REGULATOR_SLEEP_ACTIVE_OUT
);

  // Asynchronous level inputs: brown-out, clock ready, watchdog fuse
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic bor_req;
  logic clk_ready;
  logic wdt_fuse;
  logic master_clear_pin_req;
  logic illegal_req;
  logic any_src;
  logic cold_src;
  logic [rsc_pkg::DATA_W-1:0] hw_set;
  logic cause_wr;
  rsc_pkg::rsc_state_t state_q;
  rsc_pkg::rsc_state_t state_d;
  logic [rsc_pkg::STRETCH_CNT_W-1:0] stretch_q;
  logic [rsc_pkg::DATA_W-1:0] cause_q;

  localparam logic [rsc_pkg::STRETCH_CNT_W-1:0] STRETCH_LAST =
    rsc_pkg::STRETCH_CNT_W'(rsc_pkg::RESET_STRETCH_CYCLES - 1);

  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      meta_q <= 3'h0;
      sync_q <= 3'h0;
    end
    else
    begin
      meta_q <= {WATCHDOG_FUSE_ENABLE_IN, CLOCK_READY_IN,
                 BROWN_OUT_DETECT_IN};
      sync_q <= meta_q;
    end
  end

  assign bor_req = sync_q[0];
  assign clk_ready = sync_q[1];
  assign wdt_fuse = sync_q[2];

  rsc_pin_filter #(
    .CYCLES(rsc_pkg::MASTER_CLEAR_PIN_FILTER_CYCLES)
  ) u_master_clear_pin_filter (
    .clk_in(MCLK_IN),
    .rst_in(RST_IN),
    .pin_n_in(MASTER_CLEAR_PIN_N_IN),
    .req_out(master_clear_pin_req)
  );

  // Three illegal conditions share one flag
  assign illegal_req = ILLEGAL_OPCODE_IN | UNINIT_POINTER_IN
                     | SECURITY_RESET_IN;

  assign any_src = bor_req | master_clear_pin_req | SOFT_RESET_REQ_IN
                 | WATCHDOG_TIMEOUT_IN | CONFIG_MISMATCH_IN
                 | TRAP_CONFLICT_IN | illegal_req;

  assign cold_src = bor_req;

  // Hardware set terms for the cause flags
  always_comb
  begin
    hw_set = '0;
    hw_set[rsc_pkg::BOR_BIT] = bor_req;
    hw_set[rsc_pkg::PIN_RST_BIT] = master_clear_pin_req;
    hw_set[rsc_pkg::SOFT_RST_BIT] = SOFT_RESET_REQ_IN;
    hw_set[rsc_pkg::WATCHDOG_TIMEOUT_FLAG_BIT] = WATCHDOG_TIMEOUT_IN;
    hw_set[rsc_pkg::CFG_MISMATCH_BIT] = CONFIG_MISMATCH_IN;
    hw_set[rsc_pkg::TRAP_BIT] = TRAP_CONFLICT_IN;
    hw_set[rsc_pkg::ILLEGAL_BIT] = illegal_req;
    hw_set[rsc_pkg::SLEEP_BIT] = SLEEP_WAKE_IN;
    hw_set[rsc_pkg::IDLE_BIT] = IDLE_WAKE_IN;
  end

  // Sequencer: hold while any source is active, stretch, await clock
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      rsc_pkg::RSC_RUN:
      begin
        if (any_src)
        begin
          state_d = rsc_pkg::RSC_HOLD;
        end
      end
      rsc_pkg::RSC_HOLD:
      begin
        if (!any_src)
        begin
          state_d = rsc_pkg::RSC_STRETCH;
        end
      end
      rsc_pkg::RSC_STRETCH:
      begin
        if (any_src)
        begin
          state_d = rsc_pkg::RSC_HOLD;
        end
        else if (stretch_q == STRETCH_LAST)
        begin
          state_d = rsc_pkg::RSC_WAIT_CLK;
        end
      end
      rsc_pkg::RSC_WAIT_CLK:
      begin
        if (any_src)
        begin
          state_d = rsc_pkg::RSC_HOLD;
        end
        else if (clk_ready)
        begin
          state_d = rsc_pkg::RSC_RUN;
        end
      end
      default:
      begin
        state_d = rsc_pkg::RSC_HOLD;
      end
    endcase
  end

  // Power-on enters the sequence like any other hold
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      state_q <= rsc_pkg::RSC_HOLD;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN || state_q != rsc_pkg::RSC_STRETCH)
    begin
      stretch_q <= '0;
    end
    else
    begin
      stretch_q <= stretch_q + rsc_pkg::STRETCH_CNT_W'(1);
    end
  end

  // Line rises on the edge after a source appears, falls only on the
  // sequencer's release edge; one flop so every consumer sees one edge.
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      SYSTEM_RESET_LINE_OUT <= 1'b1;
    end
    else
    begin
      SYSTEM_RESET_LINE_OUT <= (state_d != rsc_pkg::RSC_RUN);
    end
  end

  // Cold marker survives until release; warm sources leave it alone
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      CLOCK_RESELECT_OUT <= 1'b1;
    end
    else if (cold_src)
    begin
      CLOCK_RESELECT_OUT <= 1'b1;
    end
    else if (state_d == rsc_pkg::RSC_RUN)
    begin
      CLOCK_RESELECT_OUT <= 1'b0;
    end
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      FETCH_START_OUT <= 1'b0;
      FETCH_ADDR_OUT <= rsc_pkg::RESET_VECTOR;
    end
    else
    begin
      FETCH_START_OUT <= (state_q == rsc_pkg::RSC_WAIT_CLK)
                       && (state_d == rsc_pkg::RSC_RUN);
      FETCH_ADDR_OUT <= rsc_pkg::RESET_VECTOR;
    end
  end

  assign cause_wr = WR_IN && (ADDR_IN == rsc_pkg::CAUSE_OFFSET);

  // Cause register is outside the reset subset: only power-on or a software write clears it,
  // so the cause survives the warm reset it records.
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      cause_q <= rsc_pkg::CAUSE_POR_VALUE;
    end
    else if (cause_wr)
    begin
      // Hardware set wins over a software clear in the same cycle
      cause_q <= (WR_DATA_IN | hw_set)
               & rsc_pkg::CAUSE_IMPL_MASK;
    end
    else
    begin
      cause_q <= cause_q | hw_set;
    end
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      WATCHDOG_ENABLE_OUT <= 1'b0;
      REGULATOR_SLEEP_ACTIVE_OUT <= 1'b0;
    end
    else
    begin
      // Fuse overrides the software enable
      WATCHDOG_ENABLE_OUT <= wdt_fuse
        | cause_q[rsc_pkg::WDT_SOFT_EN_BIT];
      REGULATOR_SLEEP_ACTIVE_OUT <=
        cause_q[rsc_pkg::REG_SLEEP_BIT];
    end
  end

  // Read data valid in the cycle after the strobe only
  always_ff @(posedge MCLK_IN)
  begin
    if (RST_IN)
    begin
      RD_DATA_OUT <= '0;
    end
    else if (RD_IN && ADDR_IN == rsc_pkg::CAUSE_OFFSET)
    begin
      RD_DATA_OUT <= cause_q & rsc_pkg::CAUSE_IMPL_MASK;
    end
    else
    begin
      RD_DATA_OUT <= '0;
    end
  end

endmodule : rsc_top
`default_nettype wire

//--- inc/rsc_pkg.sv
// Constants for the reset source combiner: register map, flag positions,
// reset values and timing counts.
// Assumes a single 100 MHz system clock.
package rsc_pkg;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MASTER_CLEAR_PIN_MIN_PULSE_NS = 2000;
  // Least time: round up
  localparam int unsigned MASTER_CLEAR_PIN_FILTER_CYCLES =
    (MASTER_CLEAR_PIN_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESET_STRETCH_NS = 100;
  localparam int unsigned RESET_STRETCH_CYCLES =
    (RESET_STRETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STRETCH_CNT_W = 4;

  // Register port
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  localparam logic [ADDR_W-1:0] CAUSE_OFFSET = 4'h0;

  // Reset cause / control register layout
  localparam int unsigned POR_BIT = 0;
  localparam int unsigned BOR_BIT = 1;
  localparam int unsigned IDLE_BIT = 2;
  localparam int unsigned SLEEP_BIT = 3;
  localparam int unsigned WATCHDOG_TIMEOUT_FLAG_BIT = 4;
  localparam int unsigned WDT_SOFT_EN_BIT = 5;
  localparam int unsigned SOFT_RST_BIT = 6;
  localparam int unsigned PIN_RST_BIT = 7;
  localparam int unsigned REG_SLEEP_BIT = 8;
  localparam int unsigned CFG_MISMATCH_BIT = 9;
  localparam int unsigned ILLEGAL_BIT = 14;
  localparam int unsigned TRAP_BIT = 15;
  localparam logic [DATA_W-1:0] CAUSE_POR_VALUE = 16'h0003;
  localparam logic [DATA_W-1:0] CAUSE_IMPL_MASK = 16'hC3FF;

  // Fetch address after release
  localparam int unsigned FETCH_ADDR_W = 24;
  localparam logic [FETCH_ADDR_W-1:0] RESET_VECTOR = 24'h000000;

  typedef enum logic [1:0] {
    RSC_RUN,
    RSC_HOLD,
    RSC_STRETCH,
    RSC_WAIT_CLK
  } rsc_state_t;

endpackage : rsc_pkg

//--- rtl/rsc_pin_filter.sv
// Glitch filter for an active-low reset pin.
// Assumes the pin is asynchronous to the clock; it is synchronised here.
`timescale 1ns/1ps
`default_nettype none
module rsc_pin_filter #(
  parameter int unsigned CYCLES = 200
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic pin_n_in,
  output logic req_out
);

  localparam int unsigned CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CYCLES - 1);

  logic meta_q;
  logic pin_n_q;
  logic [CNT_W-1:0] cnt_q;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      meta_q <= 1'b1;
      pin_n_q <= 1'b1;
    end
    else
    begin
      meta_q <= pin_n_in;
      pin_n_q <= meta_q;
    end
  end

  // Low must persist the full count; any high sample restarts it
  always_ff @(posedge clk_in)
  begin
    if (rst_in || pin_n_q)
    begin
      cnt_q <= '0;
      req_out <= 1'b0;
    end
    else if (cnt_q == CNT_LAST)
    begin
      req_out <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

endmodule : rsc_pin_filter
`default_nettype wire

//--- dv/rsc_top_monitor.sv
// Checker for rsc_top: register port and reset line timing.
// Assumes one clock and a synchronous active-high RST_IN.
`timescale 1ns/1ps
`default_nettype none
module rsc_top_monitor (
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire logic TRAP_CONFLICT_IN,
  input wire logic SOFT_RESET_REQ_IN,
  input wire logic BROWN_OUT_DETECT_IN,
  input wire logic WATCHDOG_FUSE_ENABLE_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [3:0] ADDR_IN,
  input wire logic [15:0] WR_DATA_IN,
  input wire logic [15:0] RD_DATA_OUT,
  input wire logic SYSTEM_RESET_LINE_OUT,
  input wire logic CLOCK_RESELECT_OUT,
  input wire logic FETCH_START_OUT,
  input wire logic [23:0] FETCH_ADDR_OUT,
  input wire logic WATCHDOG_ENABLE_OUT,
  input wire logic REGULATOR_SLEEP_ACTIVE_OUT
);
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (RST_IN);
  a_req_resets: assert property (
    (TRAP_CONFLICT_IN || SOFT_RESET_REQ_IN) |=> SYSTEM_RESET_LINE_OUT)
    else $error("request gave no reset");
  a_gap_zero: assert property (RD_DATA_OUT[13:10] == 4'h0)
    else $error("gap bits set");
  a_read_quiet: assert property (
    (!RD_IN || ADDR_IN != 4'h0) |=> RD_DATA_OUT == 16'h0000)
    else $error("stray read data");
  a_fetch_release: assert property (
    FETCH_START_OUT |-> $fell(SYSTEM_RESET_LINE_OUT))
    else $error("fetch not at release");
  a_fetch_zero: assert property (FETCH_ADDR_OUT == 24'h000000)
    else $error("fetch address");
  // Release needs source cycle plus full stretch
  a_stretch_min: assert property (
    $fell(SYSTEM_RESET_LINE_OUT) |-> $past(SYSTEM_RESET_LINE_OUT, 12))
    else $error("reset too short");
  a_fuse_forces: assert property (
    WATCHDOG_FUSE_ENABLE_IN [*5] |-> WATCHDOG_ENABLE_OUT)
    else $error("fuse ignored");
  a_soft_wdt: assert property (
    (!WATCHDOG_FUSE_ENABLE_IN [*4] ##0 (WR_IN && ADDR_IN == 4'h0))
    |-> ##2 WATCHDOG_ENABLE_OUT == $past(WR_DATA_IN[5], 2))
    else $error("soft enable");
  a_reg_follow: assert property (
    (WR_IN && ADDR_IN == 4'h0)
    |-> ##2 REGULATOR_SLEEP_ACTIVE_OUT == $past(WR_DATA_IN[8], 2))
    else $error("regulator bit");
  a_brown_cold: assert property (
    BROWN_OUT_DETECT_IN [*5] |-> CLOCK_RESELECT_OUT && SYSTEM_RESET_LINE_OUT)
    else $error("brown-out not cold");
  c_release: cover property ($fell(SYSTEM_RESET_LINE_OUT));
  c_cold: cover property (BROWN_OUT_DETECT_IN [*5]);
  c_read: cover property (RD_IN && ADDR_IN == 4'h0);
endmodule : rsc_top_monitor
bind rsc_top rsc_top_monitor u_rsc_top_monitor (.*);
`default_nettype wire

//--- dv/rsc_src_model.sv
// Model of the reset requesters and the reset pin.
// Assumes one request kind at a time; changes just after clock edges.
`timescale 1ns/1ps
`default_nettype none
module rsc_src_model (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic [3:0] kind_in,
  input wire logic [7:0] len_in,
  output logic [10:0] src_out
);
  logic [7:0] cnt_q = 8'h00;
  logic [3:0] kind_q = 4'h0;
  // Request held as a level for len cycles
  always_ff @(posedge clk_in)
  begin
    if (go_in)
    begin
      cnt_q <= len_in;
      kind_q <= kind_in;
    end
    else if (cnt_q != 8'h00)
      cnt_q <= cnt_q - 8'h01;
  end
  assign src_out = (cnt_q != 8'h00) ? (11'h001 << kind_q) : 11'h000;
endmodule : rsc_src_model
`default_nettype wire

//--- dv/reset_source_combiner_bench.sv
// Self-checking bench for rsc_top with the requester model.
// Assumes 100 MHz clock; clock ready dropped once to hold the release.
`timescale 1ns/1ps
`default_nettype none
module reset_source_combiner_bench;
  logic MCLK_IN = 1'b0, RST_IN = 1'b1, CLOCK_READY_IN = 1'b1;
  logic WATCHDOG_FUSE_ENABLE_IN = 1'b0, WR_IN = 1'b0, RD_IN = 1'b0;
  logic [3:0] ADDR_IN = 4'h0, kind = 4'h0;
  logic [15:0] WR_DATA_IN = 16'h0000, RD_DATA_OUT, d;
  logic MASTER_CLEAR_PIN_N_IN, BROWN_OUT_DETECT_IN, SOFT_RESET_REQ_IN;
  logic WATCHDOG_TIMEOUT_IN, CONFIG_MISMATCH_IN, TRAP_CONFLICT_IN;
  logic ILLEGAL_OPCODE_IN, UNINIT_POINTER_IN, SECURITY_RESET_IN;
  logic SLEEP_WAKE_IN, IDLE_WAKE_IN, pin_low, go = 1'b0;
  logic SYSTEM_RESET_LINE_OUT, CLOCK_RESELECT_OUT, FETCH_START_OUT;
  logic WATCHDOG_ENABLE_OUT, REGULATOR_SLEEP_ACTIVE_OUT;
  logic [23:0] FETCH_ADDR_OUT;
  logic [7:0] len = 8'h00;
  logic [10:0] src;
  int miscompares = 0, check_count = 0, seed_v;
  assign {BROWN_OUT_DETECT_IN, pin_low, IDLE_WAKE_IN, SLEEP_WAKE_IN,
    SECURITY_RESET_IN, UNINIT_POINTER_IN, ILLEGAL_OPCODE_IN,
    TRAP_CONFLICT_IN, CONFIG_MISMATCH_IN, WATCHDOG_TIMEOUT_IN,
    SOFT_RESET_REQ_IN} = src;
  assign MASTER_CLEAR_PIN_N_IN = !pin_low;
  rsc_top u_rsc_top (.*);
  rsc_src_model u_rsc_src_model (.clk_in(MCLK_IN), .go_in(go),
    .kind_in(kind), .len_in(len), .src_out(src));
  always #5 MCLK_IN = ~MCLK_IN;
  function automatic logic [15:0] cause(input int k);
    int pos[11] = '{6, 4, 9, 15, 14, 14, 14, 3, 2, 7, 1};
    return 16'h0001 << pos[k];
  endfunction : cause
  task automatic chk(input logic [23:0] s, input logic [23:0] e);
    check_count++;
    if (s !== e)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // Read when w is low: v is then the expected data
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [15:0] v);
    @(posedge MCLK_IN);
    ADDR_IN <= a;
    WR_DATA_IN <= v;
    WR_IN <= w;
    RD_IN <= !w;
    @(posedge MCLK_IN);
    WR_IN <= 1'b0;
    RD_IN <= 1'b0;
    if (!w)
      #1 chk(RD_DATA_OUT, v);
  endtask : bus
  task automatic wait_line(input logic v);
    int n;
    n = 0;
    while (SYSTEM_RESET_LINE_OUT !== v && n < 400)
    begin
      @(posedge MCLK_IN);
      #1 n++;
    end
    chk(SYSTEM_RESET_LINE_OUT, v);
  endtask : wait_line
  task automatic fire(input logic [3:0] k, input logic [7:0] n);
    @(posedge MCLK_IN);
    kind <= k;
    len <= n;
    go <= 1'b1;
    @(posedge MCLK_IN);
    go <= 1'b0;
  endtask : fire
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  initial
  begin
    seed_v = $urandom(32'h463E);
    repeat (8) @(posedge MCLK_IN);
    RST_IN <= 1'b0;
    @(posedge MCLK_IN);
    #1 chk(CLOCK_RESELECT_OUT, 1'b1);
    bus(1'b0, 4'h0, 16'h0003);
    wait_line(1'b0);
    repeat (6)
    begin
      d = 16'($urandom);
      bus(1'b1, 4'h0, d);
      bus(1'b0, 4'h0, d & 16'hC3FF);
      bus(1'b1, 4'h3, 16'hFFFF);
      bus(1'b0, 4'h3, 16'h0000);
      chk(SYSTEM_RESET_LINE_OUT, 1'b0);
    end
    $display("register test done");
    bus(1'b1, 4'h0, 16'h0120);
    @(posedge MCLK_IN);
    #1 chk({WATCHDOG_ENABLE_OUT, REGULATOR_SLEEP_ACTIVE_OUT}, 2'b11);
    WATCHDOG_FUSE_ENABLE_IN <= 1'b1;
    bus(1'b1, 4'h0, 16'h0000);
    repeat (4) @(posedge MCLK_IN);
    #1 chk({WATCHDOG_ENABLE_OUT, REGULATOR_SLEEP_ACTIVE_OUT}, 2'b10);
    WATCHDOG_FUSE_ENABLE_IN <= 1'b0;
    $display("control test done");
    // Release must wait for the clock; soft flag is cleared below
    CLOCK_READY_IN <= 1'b0;
    fire(4'h0, 8'h01);
    repeat (40) @(posedge MCLK_IN);
    #1 chk(SYSTEM_RESET_LINE_OUT, 1'b1);
    CLOCK_READY_IN <= 1'b1;
    wait_line(1'b0);
    $display("clock ready test done");
    for (int k = 0; k < 11; k++)
    begin
      // Flags cleared before each cause
      bus(1'b1, 4'h0, 16'h0000);
      fire(k, k == 9 ? 8'hD2 : (k == 10 ? 8'h14 : 8'($urandom % 3 + 1)));
      if (k == 7 || k == 8)
        repeat (4) @(posedge MCLK_IN);
      else
      begin
        wait_line(1'b1);
        chk(CLOCK_RESELECT_OUT, k == 10);
        wait_line(1'b0);
      end
      bus(1'b0, 4'h0, cause(k));
      $display("source %0d test done", k);
    end
    // Short pin pulse must be filtered out; brown-out flag cleared first
    bus(1'b1, 4'h0, 16'h0000);
    fire(4'h9, 8'h96);
    repeat (220) @(posedge MCLK_IN);
    #1 chk(SYSTEM_RESET_LINE_OUT, 1'b0);
    bus(1'b0, 4'h0, 16'h0000);
    bus(1'b1, 4'h0, 16'hFFFF);
    bus(1'b0, 4'h0, 16'hC3FF);
    RST_IN <= 1'b1;
    repeat (8) @(posedge MCLK_IN);
    RST_IN <= 1'b0;
    bus(1'b0, 4'h0, 16'h0003);
    wait_line(1'b0);
    $display("glitch and power-on test done");
    complete_run();
  end
  initial
  begin
    #200000;
    miscompares++;
    complete_run();
  end
endmodule : reset_source_combiner_bench
`default_nettype wire
